// >>> shared/csw_pkg.sv
// shared constants for the chip select and wait-state unit
`default_nettype none
package csw_pkg;

  // clocking: cpu clock is the oscillator halved
  localparam int OSC_FREQ_MHZ = 16;
  localparam int CPU_CLK_DIV  = 2;
  localparam int CPU_FREQ_MHZ = OSC_FREQ_MHZ / CPU_CLK_DIV;

  // widths
  localparam int REG_W     = 16;
  localparam int REG_ADR_W = 8;
  localparam int BUS_ADR_W = 20;
  localparam int IO_ADR_W  = 16;
  localparam int MID_NUM   = 4;
  localparam int PER_NUM   = 7;

  // register byte offsets inside the 256-byte control block
  localparam logic [7:0] OFS_UPPER_CTRL  = 8'hA0;
  localparam logic [7:0] OFS_LOWER_CTRL  = 8'hA2;
  localparam logic [7:0] OFS_PERIPH_BASE = 8'hA4;
  localparam logic [7:0] OFS_MID_BASE    = 8'hA6;
  localparam logic [7:0] OFS_MID_OPT     = 8'hA8;
  localparam logic [7:0] OFS_STATUS      = 8'hB0;
  localparam logic [7:0] OFS_RELOC       = 8'hFE;

  // reset values
  localparam logic [15:0] RST_UPPER_CTRL  = 16'hFFFB;
  localparam logic [15:0] RST_RELOC       = 16'h20FF;
  localparam logic [15:0] RST_LOWER_CTRL  = 16'h0000;
  localparam logic [15:0] RST_PERIPH_BASE = 16'h0000;
  localparam logic [15:0] RST_MID_BASE    = 16'h0000;
  localparam logic [15:0] RST_MID_OPT     = 16'h0000;

  // ready-control fields, same layout in every select register
  localparam int RDY_WAIT_LSB = 0;
  localparam int RDY_WAIT_W   = 2;
  localparam int RDY_IGN_BIT  = 2;

  // address fields
  localparam int UPPER_START_LSB = 6;
  localparam int LOWER_END_LSB   = 6;
  localparam int BOUND_W         = 8;
  localparam int MID_BASE_LSB    = 9;
  localparam int MID_BASE_W      = 7;
  localparam int MID_SIZE_LSB    = 8;
  localparam int MID_SIZE_W      = 7;
  localparam int PER_BASE_LSB    = 6;
  localparam int PER_BASE_W      = 6;

  // region codes shown in status
  localparam logic [2:0] RGN_NONE   = 3'h0;
  localparam logic [2:0] RGN_UPPER  = 3'h1;
  localparam logic [2:0] RGN_LOWER  = 3'h2;
  localparam logic [2:0] RGN_MID    = 3'h3;
  localparam logic [2:0] RGN_PERIPH = 3'h4;

  typedef enum logic {
    CSW_IDLE   = 1'b0,
    CSW_ACTIVE = 1'b1
  } csw_state_e;

endpackage : csw_pkg
`default_nettype wire

// >>> core/csw_wait_gen.sv
// wait-state counter with optional external ready
`timescale 1ns/1ps
`default_nettype none
module csw_wait_gen (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            start,
  input  wire logic                            active,
  input  wire logic [csw_pkg::RDY_WAIT_W-1:0]  waitStates,
  input  wire logic                            ignoreExt,
  input  wire logic                            extReady,
  output logic                                 done,
  output logic [csw_pkg::RDY_WAIT_W-1:0]       waited
);
  import csw_pkg::*;

  logic [RDY_WAIT_W-1:0] waited_r;
  logic                  countDone;

  // (R7) count programmed waits
  always_ff @(posedge clk) begin
    if (rst || start) begin
      waited_r <= '0;
    end else if (active && waited_r != waitStates) begin
      waited_r <= waited_r + 1'b1;
    end
  end

  assign countDone = (waited_r == waitStates);
  // (R8) external ready used or ignored
  assign done      = active && countDone && (ignoreExt || extReady);
  assign waited    = waited_r;

endmodule : csw_wait_gen
`default_nettype wire

// >>> core/csw_core.sv
// chip select decoder and wait-state unit with its control registers
//
// Functional notes
// (R1) six memory selects: upper, lower, four mid
// (R2) seven peripheral selects, 128-byte blocks above base
// (R3) peripheral base placed at I/O location 0
// (R4) region extents set by software registers
// (R5) system puts boot, vectors, program behind selects
// (R6) each region has its own ready bits
// (R7) insert zero to three programmed wait states
// (R8) ready bit chooses external ready or ignore
// (R9) 16-bit registers in 256-byte control block
// (R10) reset loads upper FFFB, relocation 20FF
// (R11) no select asserted while reset held
// (R12) clocked by CPU clock, oscillator halved
// (R13) external ready synchronised before wait logic
// (R14) async ready active high, must be high
// (R15) selects active low, always driven
// (R16) peripheral selects need both registers written
// (R17) synchronous ready tied low by system
// (R18) one select, from registered address, held stable
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module csw_core (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic [csw_pkg::REG_ADR_W-1:0]   regAddr,
  input  wire logic [csw_pkg::REG_W-1:0]       regWrData,
  input  wire logic                            regWrEn,
  input  wire logic                            regRdEn,
  output logic      [csw_pkg::REG_W-1:0]       regRdData,
  input  wire logic                            busStart,
  input  wire logic                            busMemSpace,
  input  wire logic [csw_pkg::BUS_ADR_W-1:0]   busAddr,
  output logic                                 busDone,
  input  wire logic                            asyncReadyIn,
  input  wire logic                            syncReadyIn,
  output logic                                 upperRegionSelectN,
  output logic                                 lowerRegionSelectN,
  output logic      [csw_pkg::MID_NUM-1:0]     midRegionSelectN,
  output logic      [csw_pkg::PER_NUM-1:0]     periphBlockSelectN
);
  import csw_pkg::*;

  // control registers
  logic [REG_W-1:0] upperCtrl_r;
  logic [REG_W-1:0] lowerCtrl_r;
  logic [REG_W-1:0] periphBase_r;
  logic [REG_W-1:0] midBase_r;
  logic [REG_W-1:0] midOpt_r;
  logic [REG_W-1:0] reloc_r;
  logic             lowerValid_r;
  logic             midValid_r;
  logic             periphBaseSeen_r;
  logic             midOptSeen_r;
  logic             periphEn;

  // bus cycle state
  csw_state_e             state_r;
  logic [BUS_ADR_W-1:0]   addr_r;
  logic                   memSpace_r;
  logic                   active;
  logic                   startAcc;

  // ready synchronisers
  logic asyncMeta_r;
  logic asyncSync_r;
  logic syncMeta_r;
  logic syncSync_r;
  logic extReady;

  // decode results
  logic                   upperHit;
  logic                   lowerHit;
  logic                   midHit;
  logic                   perHit;
  logic [2:0]             midK;
  logic                   midSizeOk;
  logic [BUS_ADR_W-1:0]   midBaseAddr;
  logic [BUS_ADR_W-1:0]   midOff;
  logic [BUS_ADR_W-1:0]   midSpan;
  logic [4:0]             midShift;
  logic [1:0]             midQuarter;
  logic [IO_ADR_W-1:0]    ioAddr;
  logic [IO_ADR_W-1:0]    perBaseAddr;
  logic [IO_ADR_W-1:0]    perOff;
  logic [8:0]             perBlk;
  logic [2:0]             region;
  logic [REG_W-1:0]       rdyCtrl;
  logic                   waitDone;
  logic [RDY_WAIT_W-1:0]  waited;
  logic [REG_W-1:0]       statusWord;

  // index of the highest set bit of the mid size field
  function automatic logic [2:0] highBit(input logic [MID_SIZE_W-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < MID_SIZE_W; i++) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : highBit

  // register writes
  // a write lands at its strobe edge, decode sees it next cycle

  // (R10) upper and relocation reset values
  always_ff @(posedge clk) begin
    if (rst) begin
      upperCtrl_r <= RST_UPPER_CTRL;
      reloc_r     <= RST_RELOC;
    end else if (regWrEn) begin
      if (regAddr == OFS_UPPER_CTRL) begin
        upperCtrl_r <= regWrData;
      end
      if (regAddr == OFS_RELOC) begin
        reloc_r <= regWrData;
      end
    end
  end

  // (R4) software programs region extents
  always_ff @(posedge clk) begin
    if (rst) begin
      lowerCtrl_r  <= RST_LOWER_CTRL;
      midBase_r    <= RST_MID_BASE;
      lowerValid_r <= 1'b0;
      midValid_r   <= 1'b0;
    end else if (regWrEn) begin
      if (regAddr == OFS_LOWER_CTRL) begin
        lowerCtrl_r  <= regWrData;
        lowerValid_r <= 1'b1;
      end
      if (regAddr == OFS_MID_BASE) begin
        midBase_r  <= regWrData;
        midValid_r <= 1'b1;
      end
    end
  end

  // (R3) peripheral base starts at I/O location 0
  always_ff @(posedge clk) begin
    if (rst) begin
      periphBase_r <= RST_PERIPH_BASE;
      midOpt_r     <= RST_MID_OPT;
    end else if (regWrEn) begin
      if (regAddr == OFS_PERIPH_BASE) begin
        periphBase_r <= regWrData;
      end
      if (regAddr == OFS_MID_OPT) begin
        midOpt_r <= regWrData;
      end
    end
  end

  // (R16) both registers must be touched first
  always_ff @(posedge clk) begin
    if (rst) begin
      periphBaseSeen_r <= 1'b0;
      midOptSeen_r     <= 1'b0;
    end else if (regWrEn) begin
      if (regAddr == OFS_PERIPH_BASE) begin
        periphBaseSeen_r <= 1'b1;
      end
      if (regAddr == OFS_MID_OPT) begin
        midOptSeen_r <= 1'b1;
      end
    end
  end

  assign periphEn = periphBaseSeen_r && midOptSeen_r;

  // register reads, data one cycle after the strobe
  // zero outside that cycle so a late sample cannot pass

  assign statusWord = {4'h0, periphEn, midValid_r, lowerValid_r,
                       3'h0, active, region, waited};

  // (R9) 16-bit registers, unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRdEn) begin
      unique case (regAddr)
        OFS_UPPER_CTRL:  regRdData <= upperCtrl_r;
        OFS_LOWER_CTRL:  regRdData <= lowerCtrl_r;
        OFS_PERIPH_BASE: regRdData <= periphBase_r;
        OFS_MID_BASE:    regRdData <= midBase_r;
        OFS_MID_OPT:     regRdData <= midOpt_r;
        OFS_STATUS:      regRdData <= statusWord;
        OFS_RELOC:       regRdData <= reloc_r;
        default:         regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // external ready
  // both edges synchronised: release is two cycles late, but safe

  // (R13) two flops on each ready pin
  always_ff @(posedge clk) begin
    if (rst) begin
      asyncMeta_r <= 1'b0;
      asyncSync_r <= 1'b0;
      syncMeta_r  <= 1'b0;
      syncSync_r  <= 1'b0;
    end else begin
      asyncMeta_r <= asyncReadyIn;
      asyncSync_r <= asyncMeta_r;
      syncMeta_r  <= syncReadyIn;
      syncSync_r  <= syncMeta_r;
    end
  end

  // (R14) active high; the tied-low sync pin adds nothing
  assign extReady = asyncSync_r || syncSync_r;

  // bus cycle tracking
  // a start during an access is dropped, not queued

  assign active   = (state_r == CSW_ACTIVE);
  assign startAcc = busStart && !active;

  // (R12) one cpu clock domain drives everything
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= CSW_IDLE;
    end else begin
      unique case (state_r)
        CSW_IDLE:   if (busStart) state_r <= CSW_ACTIVE;
        CSW_ACTIVE: if (waitDone) state_r <= CSW_IDLE;
      endcase
    end
  end

  // (R18) address latched once per access
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r     <= '0;
      memSpace_r <= 1'b0;
    end else if (startAcc) begin
      addr_r     <= busAddr;
      memSpace_r <= busMemSpace;
    end
  end

  // address decode from the latched address
  // latched address keeps selects steady through wait states

  // (R1) upper region runs from start block to top
  assign upperHit = memSpace_r && (addr_r[19:10] >= {2'b11,
                    upperCtrl_r[UPPER_START_LSB +: BOUND_W]});

  // (R1) lower region runs from zero to end block
  assign lowerHit = memSpace_r && lowerValid_r && (addr_r[19:10] <= {2'b00,
                    lowerCtrl_r[LOWER_END_LSB +: BOUND_W]});

  // mid region: size one-hot field, four equal quarters
  assign midK        = highBit(midOpt_r[MID_SIZE_LSB +: MID_SIZE_W]);
  assign midSizeOk   = |midOpt_r[MID_SIZE_LSB +: MID_SIZE_W];
  assign midBaseAddr = {midBase_r[MID_BASE_LSB +: MID_BASE_W], 13'h0000};
  assign midOff      = addr_r - midBaseAddr;
  assign midSpan     = 20'h02000 << midK;
  assign midShift    = 5'h0B + {2'b00, midK};
  assign midQuarter  = 2'(midOff >> midShift);
  assign midHit      = memSpace_r && midValid_r && midSizeOk &&
                       (addr_r >= midBaseAddr) && (midOff < midSpan);

  // (R2) seven 128-byte blocks above the I/O base
  assign ioAddr      = addr_r[IO_ADR_W-1:0];
  assign perBaseAddr = {periphBase_r[PER_BASE_LSB +: PER_BASE_W], 10'h000};
  assign perOff      = ioAddr - perBaseAddr;
  assign perBlk      = perOff[15:7];
  assign perHit      = !memSpace_r && periphEn && (ioAddr >= perBaseAddr) &&
                       (perBlk < 9'(PER_NUM));

  // (R18) fixed priority keeps a single select
  always_comb begin
    region = RGN_NONE;
    if (upperHit) begin
      region = RGN_UPPER;
    end else if (lowerHit) begin
      region = RGN_LOWER;
    end else if (midHit) begin
      region = RGN_MID;
    end else if (perHit) begin
      region = RGN_PERIPH;
    end
  end

  // (R6) ready bits follow the selected region
  always_comb begin
    unique case (region)
      RGN_UPPER:  rdyCtrl = upperCtrl_r;
      RGN_LOWER:  rdyCtrl = lowerCtrl_r;
      RGN_MID:    rdyCtrl = midBase_r;
      RGN_PERIPH: rdyCtrl = periphBase_r;
      // unselected cycles: no waits, end on external ready
      default:    rdyCtrl = '0;
    endcase
  end

  // (R7) wait states per region
  csw_wait_gen u_wait (
    .clk        (clk),
    .rst        (rst),
    .start      (startAcc),
    .active     (active),
    .waitStates (rdyCtrl[RDY_WAIT_LSB +: RDY_WAIT_W]),
    .ignoreExt  (rdyCtrl[RDY_IGN_BIT]),
    .extReady   (extReady),
    .done       (waitDone),
    .waited     (waited)
  );

  assign busDone = waitDone;

  // select outputs, active low, never floated
  // low only from the cycle after start through done

  // (R11) selects gated by an access in progress
  // (R15) plain drivers, also while another master holds the bus
  assign upperRegionSelectN = !(active && region == RGN_UPPER);
  assign lowerRegionSelectN = !(active && region == RGN_LOWER);

  generate
    for (genvar m = 0; m < MID_NUM; m++) begin : g_mid
      // (R1) one quarter per mid select
      assign midRegionSelectN[m] = !(active && region == RGN_MID &&
                                     midQuarter == 2'(m));
    end
    for (genvar p = 0; p < PER_NUM; p++) begin : g_per
      // (R2) one block per peripheral select
      assign periphBlockSelectN[p] = !(active && region == RGN_PERIPH &&
                                       perBlk == 9'(p));
    end
  endgenerate

endmodule : csw_core
`default_nettype wire

// >>> test/csw_core_properties.sv
// port-level checker for the chip select and wait-state unit
`timescale 1ns/1ps
`default_nettype none
module csw_core_properties (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic [csw_pkg::REG_W-1:0]     regRdData,
  input wire logic                          regRdEn,
  input wire logic                          busStart,
  input wire logic                          busMemSpace,
  input wire logic                          busDone,
  input wire logic                          upperRegionSelectN,
  input wire logic                          lowerRegionSelectN,
  input wire logic [csw_pkg::MID_NUM-1:0]   midRegionSelectN,
  input wire logic [csw_pkg::PER_NUM-1:0]   periphBlockSelectN
);
  import csw_pkg::*;
  logic        actR;
  logic        ioR;
  logic [5:0]  memN;
  logic [12:0] allN;
  assign memN = {midRegionSelectN, lowerRegionSelectN, upperRegionSelectN};
  assign allN = {periphBlockSelectN, memN};
  always_ff @(posedge clk) begin
    if (rst || busDone)
      actR <= 1'b0;
    else if (busStart)
      actR <= 1'b1;
  end
  // space of the access in flight
  always_ff @(posedge clk) begin
    if (busStart && !actR)
      ioR <= !busMemSpace;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_one_select: assert property ($countones(~allN) <= 1)
    else $error("more than one select low");
  a_reset_idle: assert property ($fell(rst) |-> &allN && !busDone
    && regRdData == '0) else $error("not idle after reset");
  a_idle_high: assert property (!actR |-> &allN)
    else $error("select low outside an access");
  a_sel_stable: assert property (actR && !busDone |=> $stable(allN))
    else $error("select changed within an access");
  a_done_active: assert property (busDone |-> actR)
    else $error("done without an access");
  a_done_pulse: assert property (busDone |=> !busDone)
    else $error("done longer than one cycle");
  a_release_sel: assert property (busDone |=> &allN)
    else $error("select held after done");
  a_periph_io: assert property (actR && !ioR |-> &periphBlockSelectN)
    else $error("peripheral select on memory access");
  a_mem_only: assert property (actR && ioR |-> &memN)
    else $error("memory select on io access");
  a_rd_window: assert property (regRdData != '0 |-> $past(regRdEn))
    else $error("read data outside its cycle");
  cover property (busDone && !upperRegionSelectN);
  cover property (busDone && !(&midRegionSelectN));
  cover property (busDone && !(&periphBlockSelectN));
endmodule : csw_core_properties
`default_nettype wire

// >>> test/csw_bus_partner.sv
// local-bus devices answering each access with async ready
`timescale 1ns/1ps
`default_nettype none
module csw_bus_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       busStart,
  input  wire logic       busDone,
  input  wire logic [3:0] latency,
  output logic            readyOut
);
  logic on;
  int   cnt;
  // ready a set latency after start, dropped on edge
  always @(posedge clk) begin
    if (rst || busDone) begin
      on <= 1'b0;
      cnt <= 0;
      readyOut <= 1'b0;
    end else if (busStart || on) begin
      on <= 1'b1;
      cnt <= cnt + 1;
      readyOut <= (cnt + 1 >= latency);
    end
  end
endmodule : csw_bus_partner
`default_nettype wire

// >>> test/chip_select_wait_unit_bench.sv
// self-checking bench for the chip select and wait-state unit
`timescale 1ns/1ps
`default_nettype none
module chip_select_wait_unit_bench;
  import csw_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = '0;
  logic [15:0] regWrData = '0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic        busStart = 1'b0;
  logic        busMemSpace = 1'b0;
  logic [19:0] busAddr = '0;
  logic        busDone;
  logic        asyncReadyIn;
  logic        upperRegionSelectN;
  logic        lowerRegionSelectN;
  logic [3:0]  midRegionSelectN;
  logic [6:0]  periphBlockSelectN;
  logic [12:0] selN;
  logic [3:0]  latency = '0;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          rg [int];
  bit          wrt [int];
  logic [7:0]  offs [6] = '{OFS_UPPER_CTRL, OFS_LOWER_CTRL,
    OFS_PERIPH_BASE, OFS_MID_BASE, OFS_MID_OPT, OFS_RELOC};
  assign selN = {periphBlockSelectN, midRegionSelectN,
                 lowerRegionSelectN, upperRegionSelectN};
  always #12.5 clk = ~clk;
  csw_core i_dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .busStart(busStart), .busMemSpace(busMemSpace), .busAddr(busAddr),
    .busDone(busDone), .asyncReadyIn(asyncReadyIn),
    .syncReadyIn(1'b0),
    .upperRegionSelectN(upperRegionSelectN),
    .lowerRegionSelectN(lowerRegionSelectN),
    .midRegionSelectN(midRegionSelectN),
    .periphBlockSelectN(periphBlockSelectN));
  csw_bus_partner i_part (.clk(clk), .rst(rst), .busStart(busStart),
    .busDone(busDone), .latency(latency), .readyOut(asyncReadyIn));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  // model state as left by reset
  task automatic mreset();
    foreach (offs[i]) begin
      rg[offs[i]] = 0;
      wrt[offs[i]] = 0;
    end
    rg[OFS_UPPER_CTRL] = RST_UPPER_CTRL;
    rg[OFS_RELOC] = RST_RELOC;
  endtask : mreset
  // select index 0 upper, 1 lower, 2..5 mid, 6..12 peripheral
  function automatic int decode(input bit mem, input int a, output int rdy);
    int up;
    int lo;
    int mb;
    int sz;
    int off;
    up = rg[OFS_UPPER_CTRL];
    lo = rg[OFS_LOWER_CTRL];
    mb = rg[OFS_MID_BASE][15:9] << 13;
    off = (a & 'hFFFF) - (rg[OFS_PERIPH_BASE][11:6] << 10);
    sz = 0;
    for (int k = 0; k < 7; k++)
      if (rg[OFS_MID_OPT][8+k])
        sz = 8192 << k;
    decode = -1;
    rdy = 0;
    if (mem && a[19:10] >= {2'b11, up[13:6]}) begin
      decode = 0;
      rdy = up;
    end else if (mem && wrt[OFS_LOWER_CTRL] && a[19:10] <= lo[13:6]) begin
      decode = 1;
      rdy = lo;
    end else if (mem && wrt[OFS_MID_BASE] && sz > 0 && a >= mb
                 && a < mb + sz) begin
      decode = 2 + (a - mb) / (sz / 4);
      rdy = rg[OFS_MID_BASE];
    end else if (!mem && wrt[OFS_PERIPH_BASE] && wrt[OFS_MID_OPT]
                 && off >= 0 && off < 896) begin
      decode = 6 + off / 128;
      rdy = rg[OFS_PERIPH_BASE];
    end
  endfunction : decode
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    if (rg.exists(a)) begin
      rg[a] = d;
      wrt[a] = 1;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 chk(regRdData, rg.exists(a) ? 16'(rg[a]) : 16'h0);
    @(posedge clk);
  endtask : rd
  task automatic acc(input bit mem, input int a, input int l);
    int idx;
    int rdy;
    int w;
    int c;
    logic [15:0] e;
    idx = decode(mem, a, rdy);
    w = rdy[1:0];
    e = (idx < 0) ? 16'h1FFF : 16'h1FFF & ~(16'h1 << idx);
    latency <= 4'(l);
    busMemSpace <= mem;
    busAddr <= 20'(a);
    busStart <= 1'b1;
    @(posedge clk);
    busStart <= 1'b0;
    c = 0;
    forever begin
      #1 c++;
      chk({3'h0, selN}, e);
      if (busDone === 1'b1 || c > 40)
        break;
      @(posedge clk);
    end
    // idle gap lets the synchronised ready fall
    repeat (3) @(posedge clk);
    if (rdy[2])
      chk(16'(c), 16'(w + 1));
    else
      chk(16'(c >= w + 1 && c > l + 1 && c <= w + l + 4), 16'h1);
  endtask : acc
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h1f4a614a));
    mreset();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (offs[i])
      rd(offs[i]);
    wr(8'h10, 16'hFFFF);
    rd(8'h10);
    wr(OFS_RELOC, 16'h5A5A);
    rd(OFS_RELOC);
    note("registers");
    acc(1, 'hFFFF0, 1);
    acc(1, 'hFFC00, 7);
    acc(1, 'hFFBFF, 2);
    acc(0, 'h00100, 1);
    note("upper default");
    for (int i = 0; i < 8; i++) begin
      wr(OFS_LOWER_CTRL, 16'((8'h0F << 6) | i));
      acc(1, $urandom_range('h3FFF), $urandom_range(6));
    end
    acc(1, 'h4000, 1);
    note("lower waits");
    wr(OFS_PERIPH_BASE, 16'h0005);
    acc(0, 'h0010, 1);
    wr(OFS_MID_OPT, 16'h0100);
    for (int i = 0; i < 8; i++)
      acc(0, i * 128 + $urandom_range(127), 2);
    note("peripheral blocks");
    wr(OFS_MID_BASE, 16'h2003);
    for (int q = 0; q < 5; q++)
      acc(1, 'h20000 + q * 'h800 + $urandom_range('h7FF), 3);
    regAddr <= OFS_STATUS;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    // three enable flags at 11..9, idle, no region, no waits
    #1 chk(regRdData, 16'h0E00);
    @(posedge clk);
    note("mid quarters");
    latency <= 4'hF;
    busMemSpace <= 1'b1;
    busAddr <= 20'hFFFF0;
    busStart <= 1'b1;
    @(posedge clk);
    busStart <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    mreset();
    repeat (2) @(posedge clk);
    #1 chk({3'h0, selN}, 16'h1FFF);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (offs[i])
      rd(offs[i]);
    acc(1, 'h00100, 1);
    note("reset in access");
    wr(OFS_UPPER_CTRL, 16'h3C06);
    acc(1, 'hFC000, 1);
    acc(1, 'hFBFFF, 1);
    note("upper programmed");
    summarize();
  end
endmodule : chip_select_wait_unit_bench
bind csw_core csw_core_properties i_props (
  .clk(clk), .rst(rst), .regRdData(regRdData), .regRdEn(regRdEn),
  .busStart(busStart), .busMemSpace(busMemSpace), .busDone(busDone),
  .upperRegionSelectN(upperRegionSelectN),
  .lowerRegionSelectN(lowerRegionSelectN),
  .midRegionSelectN(midRegionSelectN),
  .periphBlockSelectN(periphBlockSelectN));
`default_nettype wire
